// >>> include/rdcr_pkg.sv
// rdcr_pkg: shared constants and carrier types for the redriver register bank.
// assumes: one 100 MHz clock domain; the bus side is a two-wire serial target.
package rdcr_pkg;

    // strap levels, 3-bit code per strap pin (0..4, 4 = floating)
    localparam logic [2:0] LEVEL_FLOAT = 3'h4;
    localparam logic [6:0] ADDR_BASE = 7'h18;
    localparam logic [6:0] ADDR_HIGH_STEP = 7'h08;
    localparam logic [6:0] ADDR_LOW_STEP = 7'h02;

    // address windows, upper three bits of the register pointer
    localparam logic [2:0] WIN_BCAST_ALL = 3'h4;
    localparam logic [2:0] WIN_BCAST_LO = 3'h5;
    localparam logic [2:0] WIN_BCAST_HI = 3'h6;
    localparam logic [2:0] WIN_SHARED = 3'h7;
    localparam int NUM_CHAN = 4;

    // channel offsets
    localparam logic [4:0] OFF_BOOST = 5'h01;
    localparam logic [4:0] OFF_PROFILE = 5'h03;
    localparam logic [4:0] OFF_TEST = 5'h04;
    localparam int TEST_DIS_BIT = 2;
    localparam logic [2:0] FLAT_GAIN_RST = 3'h5;

    // shared registers
    localparam logic [7:0] REG_GENERAL = 8'he2;
    localparam logic [7:0] REG_LOAD_STATUS = 8'he3;
    localparam logic [7:0] REG_PART_LOW = 8'hf0;
    localparam logic [7:0] REG_PART_MAIN = 8'hf1;
    localparam int GEN_REGS_RST_BIT = 6;
    localparam int GEN_PRIMARY_RST_BIT = 5;
    localparam int GEN_FORCE_LOAD_BIT = 0;

    // identification, values arbitrary
    localparam logic [2:0] PART_CODE_LOW = 3'h5;
    localparam logic [7:0] PART_CODE_MAIN = 8'h5a;

    localparam logic [3:0] BIT_CNT_BYTE = 4'h8;

    typedef struct packed {
        logic first_boost_bypass;
        logic [3:0] first_boost_level;
        logic [2:0] second_boost_level;
        logic [3:0] midband_profile;
        logic [2:0] flat_gain;
        logic factory_test_disable;
    } rdcr_chan_cfg_t;

    typedef struct packed {
        logic complete;
        logic failed;
        logic [1:0] attempts;
    } rdcr_load_stat_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_REG = 4'b0011,
        ST_REG_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } rdcr_state_t;

endpackage

// >>> design/rdcr_strap_decode.sv
// rdcr_strap_decode: syncs the two address straps and latches the target address.
// assumes: strap levels are static codes 0..4; latched on the first cycle after reset.
`timescale 1ns/100ps
`default_nettype none
module rdcr_strap_decode
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // straps
    input wire logic [2:0] addr_strap_high_i,
    input wire logic [2:0] addr_strap_low_i,
    // decoded address
    output logic [6:0] own_addr_o,
    output logic addr_valid_o
);
    import rdcr_pkg::*;

    logic [5:0] strap_q1;
    logic [5:0] strap_q2;
    logic captured;

    always_ff @(posedge clk_i)
    begin
        strap_q1 <= {addr_strap_high_i, addr_strap_low_i};
        strap_q2 <= strap_q1;
    end

    // caught once after release, so straps never disturb a live address
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            captured <= 1'b0;
            own_addr_o <= 7'h00;
            addr_valid_o <= 1'b0;
        end
        else if (!captured)
        begin
            captured <= 1'b1;
            own_addr_o <= ADDR_BASE + ADDR_HIGH_STEP * {4'h0, strap_q2[5:3]}
                + ADDR_LOW_STEP * {4'h0, strap_q2[2:0]};
            addr_valid_o <= (strap_q2[2:0] < LEVEL_FLOAT) && (strap_q2[5:3] < LEVEL_FLOAT);
        end
    end
endmodule
`default_nettype wire

// >>> design/rdcr_channel_regs.sv
// rdcr_channel_regs: one channel's configuration set and its read mux.
// assumes: the caller resolves broadcast windows into per-channel write enables.
`timescale 1ns/100ps
`default_nettype none
module rdcr_channel_regs
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register access
    input wire logic wr_en_i,
    input wire logic [4:0] offset_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // configuration
    output rdcr_pkg::rdcr_chan_cfg_t cfg_o
);
    import rdcr_pkg::*;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cfg_o <= '0;
            cfg_o.flat_gain <= FLAT_GAIN_RST;
        end
        else if (wr_en_i)
        begin
            unique case (offset_i)
                OFF_BOOST:
                begin
                    {cfg_o.first_boost_bypass, cfg_o.first_boost_level, cfg_o.second_boost_level} <= wdata_i;
                end
                OFF_PROFILE:
                begin
                    {cfg_o.midband_profile, cfg_o.flat_gain} <= wdata_i[6:0];
                end
                OFF_TEST:
                begin
                    cfg_o.factory_test_disable <= wdata_i[TEST_DIS_BIT];
                end
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        rdata_o = 8'h00;
        unique case (offset_i)
            OFF_BOOST: rdata_o = {cfg_o.first_boost_bypass, cfg_o.first_boost_level, cfg_o.second_boost_level};
            OFF_PROFILE: rdata_o = {1'b0, cfg_o.midband_profile, cfg_o.flat_gain};
            OFF_TEST: rdata_o[TEST_DIS_BIT] = cfg_o.factory_test_disable;
            default: rdata_o = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

// >>> design/rdcr_register_bank.sv
// rdcr_register_bank: two-wire serial target and the redriver's register map.
// assumes: load sequencer and primary engine live outside and use the pulses here.
// Function
// - answer on the address given by the two five-level straps; float on either strap is reserved
// - shared registers reachable at any time regardless of channel state
// - four identical channel sets, written singly or by broadcast
// - channel sets start at 0x00, 0x20, 0x40, 0x60 plus offset
// - window 0x80 writes all four channels, reads channel 0
// - window 0xA0 writes channels 0 and 1, reads channel 0
// - window 0xC0 writes channels 2 and 3, reads channel 2
// - window 0xE0 holds the shared registers
// - 0xE2 bit 6 resets all bus registers, bit 5 resets primary; both self-clear
// - 0xE2 bit 0 forces a configuration load and self-clears
// - 0xE3 high nibble: complete, failed, two-bit attempt count
// - 0xE3 low nibble: same layout for the second load
// - fixed read-only part codes at 0xF0 bits 3:1 and 0xF1
// - offset 0x01 holds bypass, four-bit first boost, three-bit second boost
// - offset 0x03 holds midband profile and flat gain, gain resets to 101
// - offset 0x04 bit 2 resets to 0 (test on); write 1 for normal use
// - bus clock at most 400 kHz
`timescale 1ns/100ps
`default_nettype none
module rdcr_register_bank
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // address straps
    input wire logic [2:0] addr_strap_high_i,
    input wire logic [2:0] addr_strap_low_i,
    // serial bus pins, data is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // configuration load status from the sequencer
    input wire rdcr_pkg::rdcr_load_stat_t load_stat_first_i,
    input wire rdcr_pkg::rdcr_load_stat_t load_stat_second_i,
    // control pulses
    output logic load_start_o,
    output logic primary_reset_o,
    // channel configuration
    output wire rdcr_pkg::rdcr_chan_cfg_t [3:0] chan_cfg_o
);
    import rdcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [3:0] write_mask(input logic [2:0] win);
        unique case (win)
            3'h0: write_mask = 4'b0001;
            3'h1: write_mask = 4'b0010;
            3'h2: write_mask = 4'b0100;
            3'h3: write_mask = 4'b1000;
            WIN_BCAST_ALL: write_mask = 4'b1111;
            WIN_BCAST_LO: write_mask = 4'b0011;
            WIN_BCAST_HI: write_mask = 4'b1100;
            WIN_SHARED: write_mask = 4'b0000;
        endcase
    endfunction

    function automatic logic [1:0] read_chan(input logic [2:0] win);
        unique case (win)
            3'h0: read_chan = 2'h0;
            3'h1: read_chan = 2'h1;
            3'h2: read_chan = 2'h2;
            3'h3: read_chan = 2'h3;
            WIN_BCAST_ALL: read_chan = 2'h0;
            WIN_BCAST_LO: read_chan = 2'h0;
            WIN_BCAST_HI: read_chan = 2'h2;
            WIN_SHARED: read_chan = 2'h0;
        endcase
    endfunction

    function automatic logic [7:0] boost_byte(input rdcr_chan_cfg_t c);
        boost_byte = {c.first_boost_bypass, c.first_boost_level, c.second_boost_level};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection

    logic scl_q1;
    logic scl_q2;
    logic scl_q3;
    logic sda_q1;
    logic sda_q2;
    logic sda_q3;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    // 100 MHz oversamples a 400 kHz bus many times over, so three cycles of lag is harmless
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            {scl_q1, scl_q2, scl_q3} <= 3'b111;
            {sda_q1, sda_q2, sda_q3} <= 3'b111;
        end
        else
        begin
            {scl_q1, scl_q2, scl_q3} <= {scl_i, scl_q1, scl_q2};
            {sda_q1, sda_q2, sda_q3} <= {sda_i, sda_q1, sda_q2};
        end
    end

    assign scl_rise = scl_q2 && !scl_q3;
    assign scl_fall = !scl_q2 && scl_q3;
    assign bus_start = scl_q2 && scl_q3 && !sda_q2 && sda_q3;
    assign bus_stop = scl_q2 && scl_q3 && sda_q2 && !sda_q3;

    ////////////////////////////////////////////////////////////////////////////
    // own address

    logic [6:0] own_addr;
    logic addr_valid;

    rdcr_strap_decode u_strap
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .addr_strap_high_i(addr_strap_high_i),
        .addr_strap_low_i(addr_strap_low_i),
        .own_addr_o(own_addr),
        .addr_valid_o(addr_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // serial target

    rdcr_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic wr_en;
    logic [7:0] rd_byte;
    logic [7:0] next_ptr;

    assign next_ptr = ptr + 8'h01;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
            wr_en <= 1'b0;
            sda_oe_o <= 1'b0;
            sda_o <= 1'b0;
        end
        else
        begin
            wr_en <= 1'b0;
            sda_o <= 1'b0;
            if (bus_start)
            begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe_o <= 1'b0;
            end
            else if (bus_stop)
            begin
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end
            else if (scl_rise)
            begin
                unique case (state)
                    ST_ADDR, ST_REG, ST_WDATA:
                    begin
                        rx <= {rx[6:0], sda_q2};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RDATA: bit_cnt <= bit_cnt + 4'h1;
                    ST_RDATA_ACK: nack <= sda_q2;
                    default:
                    begin
                    end
                endcase
            end
            else if (scl_fall)
            begin
                unique case (state)
                    ST_IDLE:
                    begin
                    end
                    ST_ADDR:
                    begin
                        if (bit_cnt == BIT_CNT_BYTE)
                        begin
                            if (addr_valid && rx[7:1] == own_addr)
                            begin
                                sda_oe_o <= 1'b1;
                                rw <= rx[0];
                                state <= ST_ADDR_ACK;
                            end
                            else
                            begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK:
                    begin
                        bit_cnt <= 4'h0;
                        if (rw)
                        begin
                            tx <= {rd_byte[6:0], 1'b0};
                            sda_oe_o <= !rd_byte[7];
                            state <= ST_RDATA;
                        end
                        else
                        begin
                            sda_oe_o <= 1'b0;
                            state <= ST_REG;
                        end
                    end
                    ST_REG:
                    begin
                        if (bit_cnt == BIT_CNT_BYTE)
                        begin
                            ptr <= rx;
                            sda_oe_o <= 1'b1;
                            state <= ST_REG_ACK;
                        end
                    end
                    ST_REG_ACK, ST_WDATA_ACK:
                    begin
                        sda_oe_o <= 1'b0;
                        bit_cnt <= 4'h0;
                        state <= ST_WDATA;
                    end
                    ST_WDATA:
                    begin
                        if (bit_cnt == BIT_CNT_BYTE)
                        begin
                            wr_en <= 1'b1;
                            sda_oe_o <= 1'b1;
                            state <= ST_WDATA_ACK;
                        end
                    end
                    ST_RDATA:
                    begin
                        if (bit_cnt == BIT_CNT_BYTE)
                        begin
                            sda_oe_o <= 1'b0;
                            state <= ST_RDATA_ACK;
                        end
                        else
                        begin
                            sda_oe_o <= !tx[7];
                            tx <= {tx[6:0], 1'b0};
                        end
                    end
                    ST_RDATA_ACK:
                    begin
                        state <= nack ? ST_IDLE : ST_RDATA;
                        bit_cnt <= 4'h0;
                        ptr <= nack ? ptr : next_ptr;
                        tx <= {rd_byte[6:0], 1'b0};
                        sda_oe_o <= !nack && !rd_byte[7];
                    end
                endcase
            end
            else if (wr_en)
            begin
                ptr <= next_ptr;
            end
        end
    end

    // the next byte of a read burst is fetched at the pointer after the increment
    logic [7:0] read_addr;
    assign read_addr = (state == ST_RDATA_ACK) ? next_ptr : ptr;

    ////////////////////////////////////////////////////////////////////////////
    // channel sets

    logic soft_rst;
    logic [3:0] chan_wr;
    logic [7:0] chan_rdata [NUM_CHAN];

    assign chan_wr = wr_en ? write_mask(ptr[7:5]) : 4'h0;

    generate
        for (genvar g = 0; g < NUM_CHAN; g++)
        begin : g_chan
            rdcr_channel_regs u_chan
            (
                .clk_i(clk_i),
                .reset_i(reset_i || soft_rst),
                .wr_en_i(chan_wr[g]),
                .offset_i(read_addr[4:0]),
                .wdata_i(rx),
                .rdata_o(chan_rdata[g]),
                .cfg_o(chan_cfg_o[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // shared registers

    // self-clearing bits live one cycle, the pulse itself is the readback
    always_ff @(posedge clk_i)
    begin
        if (reset_i || soft_rst)
        begin
            soft_rst <= 1'b0;
            primary_reset_o <= 1'b0;
            load_start_o <= 1'b0;
        end
        else
        begin
            soft_rst <= wr_en && ptr == REG_GENERAL && rx[GEN_REGS_RST_BIT];
            primary_reset_o <= wr_en && ptr == REG_GENERAL && rx[GEN_PRIMARY_RST_BIT];
            load_start_o <= wr_en && ptr == REG_GENERAL && rx[GEN_FORCE_LOAD_BIT];
        end
    end

    always_comb
    begin
        rd_byte = 8'h00;
        if (read_addr[7:5] != WIN_SHARED)
        begin
            rd_byte = chan_rdata[read_chan(read_addr[7:5])];
        end
        else
        begin
            unique case (read_addr)
                REG_GENERAL: rd_byte = {1'b0, soft_rst, primary_reset_o, 4'h0, load_start_o};
                REG_LOAD_STATUS: rd_byte = {load_stat_first_i, load_stat_second_i};
                REG_PART_LOW: rd_byte = {4'h0, PART_CODE_LOW, 1'b0};
                REG_PART_MAIN: rd_byte = PART_CODE_MAIN;
                default: rd_byte = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    addr_ack_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == ST_ADDR && scl_fall && !bus_start && !bus_stop && bit_cnt == BIT_CNT_BYTE
         && addr_valid && rx[7:1] == own_addr) |=> (sda_oe_o && state == ST_ADDR_ACK))
        else $error("own address not acknowledged");

    soft_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
        soft_rst |=> (chan_cfg_o[0].flat_gain == FLAT_GAIN_RST && chan_cfg_o[3] == chan_cfg_o[0]
                      && !chan_cfg_o[1].factory_test_disable))
        else $error("register reset left a channel dirty");

    self_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (soft_rst || primary_reset_o || load_start_o) |=> ##1 !(soft_rst || primary_reset_o || load_start_o))
        else $error("self-clearing bit stuck");

    force_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_en && ptr == REG_GENERAL && rx[GEN_FORCE_LOAD_BIT]) |=> load_start_o ##1 !load_start_o)
        else $error("forced load not launched as one pulse");

    bcast_all_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_en && ptr == {WIN_BCAST_ALL, OFF_BOOST}) |=>
        (boost_byte(chan_cfg_o[0]) == $past(rx) && boost_byte(chan_cfg_o[1]) == $past(rx)
         && boost_byte(chan_cfg_o[2]) == $past(rx) && boost_byte(chan_cfg_o[3]) == $past(rx)))
        else $error("broadcast did not reach all channels");

    pair_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_en && ptr == {WIN_BCAST_LO, OFF_PROFILE} && !soft_rst) |=>
        ($stable(chan_cfg_o[2]) && $stable(chan_cfg_o[3])
         && {chan_cfg_o[0].midband_profile, chan_cfg_o[0].flat_gain} == $past(rx[6:0])
         && {chan_cfg_o[1].midband_profile, chan_cfg_o[1].flat_gain} == $past(rx[6:0])))
        else $error("pair broadcast hit the wrong channels");

    upper_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (read_addr == {WIN_BCAST_HI, OFF_BOOST}) |-> rd_byte == boost_byte(chan_cfg_o[2]))
        else $error("upper pair read not from channel 2");

    status_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (read_addr == REG_LOAD_STATUS) |-> rd_byte == {load_stat_first_i, load_stat_second_i})
        else $error("load status misplaced");

    part_code_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (read_addr == REG_PART_MAIN) |-> rd_byte == PART_CODE_MAIN)
        else $error("part code wrong");

    unused_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (read_addr[4:0] == 5'h00 && read_addr[7:5] != WIN_SHARED) |-> rd_byte == 8'h00)
        else $error("unused offset reads nonzero");
endmodule
`default_nettype wire

// >>> test/rdcr_host_model.sv
// rdcr_host_model: behavioural two-wire bus host for the register bank.
// assumes: sda_i is the resolved wire with a pull-up; this model alone drives scl.
`timescale 1ns/100ps
`default_nettype none
module rdcr_host_model
(
    // clock
    input wire logic clk_i,
    // bus pins
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial scl_o = 1'b1;
    initial sda_oe_o = 1'b0;
    ////////////////////////////////////////////////////////////////
    task automatic half();
        repeat (8) @(posedge clk_i);
    endtask
    // data moves two cycles into scl low, clear of both edges
    task automatic bit_x(input logic b, output logic r);
        repeat (2) @(posedge clk_i);
        sda_oe_o <= ~b;
        repeat (6) @(posedge clk_i);
        scl_o <= 1'b1;
        half();
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    // also serves as repeated start when scl is low
    task automatic start();
        repeat (2) @(posedge clk_i);
        sda_oe_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b1;
        half();
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        repeat (2) @(posedge clk_i);
        sda_oe_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b0;
        half();
    endtask
    // last = 1 releases the ninth bit: device ack on writes, host nack on reads
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(last, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic k0, k1;
        start();
        xfer({a, 1'b0}, 1'b1, q, k0);
        xfer(p, 1'b1, q, k1);
        xfer(d, 1'b1, q, ok);
        stop();
        ok = ok & k0 & k1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] q);
        logic k;
        start();
        xfer({a, 1'b0}, 1'b1, q, k);
        xfer(p, 1'b1, q, k);
        start();
        xfer({a, 1'b1}, 1'b1, q, k);
        xfer(8'hff, 1'b1, q, k);
        stop();
    endtask
endmodule
`default_nettype wire

// >>> test/rdcr_register_bank_tb.sv
// rdcr_register_bank_tb: self-checking bench for the register bank.
// assumes: rdcr_host_model is the bus host; load status is held at fixed values.
`timescale 1ns/100ps
`default_nettype none
module rdcr_register_bank_tb;
    import rdcr_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] strap_hi = 3'h3;
    logic [2:0] strap_lo = 3'h2;
    logic [6:0] dev_addr = 7'h34;
    logic scl, sda_dev, sda_dev_oe, sda_host_oe, load_start, primary_reset, ok;
    logic [7:0] q;
    rdcr_load_stat_t stat_a = 4'ha;
    rdcr_load_stat_t stat_b = 4'h7;
    rdcr_chan_cfg_t [3:0] cfg;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_load = 0;
    int n_prim = 0;
    // pull-up: low while either party enables
    wire logic sda;
    assign sda = ~(sda_dev_oe | sda_host_oe);
    initial forever #5 clk = ~clk;
    always @(posedge clk)
    begin
        n_load <= n_load + int'(load_start);
        n_prim <= n_prim + int'(primary_reset);
    end
    rdcr_register_bank rdcr_register_bank_i (.clk_i(clk), .reset_i(reset), .addr_strap_high_i(strap_hi),
        .addr_strap_low_i(strap_lo), .scl_i(scl), .sda_i(sda), .sda_o(sda_dev), .sda_oe_o(sda_dev_oe),
        .load_stat_first_i(stat_a), .load_stat_second_i(stat_b), .load_start_o(load_start),
        .primary_reset_o(primary_reset), .chan_cfg_o(cfg));
    rdcr_host_model rdcr_host_model_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(sda_host_oe));
    ////////////////////////////////////////////////////////////////
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [7:0] boost(input int c);
        return {cfg[c].first_boost_bypass, cfg[c].first_boost_level, cfg[c].second_boost_level};
    endfunction
    task automatic rd_chk(input string name, input logic [7:0] p, input logic [7:0] exp);
        rdcr_host_model_i.rd(dev_addr, p, q);
        chk8(name, exp, q);
    endtask
    task automatic wr_ok(input logic [7:0] p, input logic [7:0] d);
        rdcr_host_model_i.wr(dev_addr, p, d, ok);
        chk8("write ack", 8'h01, {7'h00, ok});
    endtask
    // straps must settle before release, they are latched once
    task automatic do_reset(input logic [2:0] hi, input logic [2:0] lo);
        strap_hi <= hi;
        strap_lo <= lo;
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        for (int c = 0; c < NUM_CHAN; c++)
        begin
            rd_chk("boost", 8'(c * 32 + 1), 8'h00);
            rd_chk("profile", 8'(c * 32 + 3), 8'h05);
            rd_chk("test", 8'(c * 32 + 4), 8'h00);
        end
    endtask
    task automatic t_channels();
        for (int c = 0; c < NUM_CHAN; c++)
            wr_ok(8'(c * 32 + 1), 8'(8'h81 + c * 17));
        for (int c = 0; c < NUM_CHAN; c++)
        begin
            rd_chk("boost", 8'(c * 32 + 1), 8'(8'h81 + c * 17));
            chk8("cfg boost", 8'(8'h81 + c * 17), boost(c));
        end
        wr_ok(8'h23, 8'hff);
        rd_chk("profile", 8'h23, 8'h7f);
        chk8("cfg gain", 8'h7f, {1'b0, cfg[1].midband_profile, cfg[1].flat_gain});
        wr_ok(8'h24, 8'hff);
        rd_chk("test", 8'h24, 8'h04);
        chk8("cfg test", 8'h01, {7'h00, cfg[1].factory_test_disable});
        rd_chk("unused", 8'h3f, 8'h00);
    endtask
    task automatic t_broadcast();
        wr_ok(8'h81, 8'h5a);
        for (int c = 0; c < NUM_CHAN; c++)
            chk8("all", 8'h5a, boost(c));
        wr_ok(8'ha1, 8'h33);
        wr_ok(8'hc1, 8'h44);
        for (int c = 0; c < NUM_CHAN; c++)
            chk8("pair", (c < 2) ? 8'h33 : 8'h44, boost(c));
        wr_ok(8'ha3, 8'h2b);
        chk8("pair gain", 8'h2b, {1'b0, cfg[1].midband_profile, cfg[1].flat_gain});
        chk8("pair spared", 8'h05, {1'b0, cfg[3].midband_profile, cfg[3].flat_gain});
        rd_chk("read all", 8'h81, 8'h33);
        rd_chk("read low", 8'ha1, 8'h33);
        rd_chk("read high", 8'hc1, 8'h44);
    endtask
    task automatic t_shared();
        rd_chk("status", 8'he3, 8'ha7);
        rd_chk("part low", 8'hf0, {4'h0, PART_CODE_LOW, 1'b0});
        wr_ok(8'hf1, 8'h00);
        rd_chk("part main", 8'hf1, PART_CODE_MAIN);
        rd_chk("shared unused", 8'he5, 8'h00);
        wr_ok(8'he2, 8'h01);
        chk8("load pulses", 8'h01, 8'(n_load));
        wr_ok(8'he2, 8'h20);
        chk8("primary pulses", 8'h01, 8'(n_prim));
        rd_chk("general", 8'he2, 8'h00);
        wr_ok(8'he2, 8'h40);
        chk8("cleared boost", 8'h00, boost(2));
        rd_chk("cleared gain", 8'h43, 8'h05);
        chk8("load only once", 8'h01, 8'(n_load));
    endtask
    task automatic t_address();
        do_reset(3'h2, 3'h2);
        rdcr_host_model_i.wr(7'h34, 8'h01, 8'h11, ok);
        chk8("old address", 8'h00, {7'h00, ok});
        dev_addr = 7'h2c;
        rd_chk("new address", 8'h01, 8'h00);
        do_reset(3'h2, 3'h4);
        rdcr_host_model_i.wr(7'h2c, 8'h01, 8'h11, ok);
        chk8("reserved", 8'h00, {7'h00, ok});
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        do_reset(3'h3, 3'h2);
        t_reset_values();
        t_channels();
        t_broadcast();
        t_shared();
        t_address();
        give_verdict();
    end
    // about 26.5k cycles are expected
    initial
    begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
